// *** pkg/ppd_consts.svh ***
// Offsets, field positions, legal values and reset values of the
// partition page decoder. Definitions only; included by bare name.
`ifndef PPD_CONSTS_SVH
`define PPD_CONSTS_SVH

// Byte positions within the page
`define PPD_IDX_CODE     4'h0
`define PPD_IDX_LEN      4'h1
`define PPD_IDX_MAXADD   4'h2
`define PPD_IDX_ADDL     4'h3
`define PPD_IDX_SEL      4'h4
`define PPD_IDX_SIZE_HI  4'h8
`define PPD_IDX_SIZE_LO  4'h9
`define PPD_CNT_MAX      4'hF

// Bit positions in byte 0 and byte 4
`define PPD_SAVABLE_BIT  7
`define PPD_FIXED_BIT    7
`define PPD_PRESET_BIT   6
`define PPD_HOST_BIT     5
`define PPD_UNIT_HI      4
`define PPD_UNIT_LO      3

// Legal values
`define PPD_PAGE_CODE    6'h11
`define PPD_LEN_SHORT    8'h06
`define PPD_LEN_LONG     8'h08
`define PPD_BYTES_SHORT  4'h8
`define PPD_BYTES_LONG   4'hA
`define PPD_ADDL_NONE    8'h00
`define PPD_ADDL_ONE     8'h01

// Size unit codes and conversion
`define PPD_UNIT_BYTE    2'h0
`define PPD_UNIT_KBYTE   2'h1
`define PPD_UNIT_MBYTE   2'h2
`define PPD_UNIT_BAD     2'h3
`define PPD_KB_SHIFT     10
`define PPD_MB_MIN       16'h0001

// Reset values
`define PPD_RST_BYTE     8'h00
`define PPD_RST_SIZE     16'h0000
`define PPD_RST_CNT      4'h0

`endif

// *** pkg/ppd_pkg.sv ***
// Types of the partition page decoder: states, actions, result.
// Assumes the constants header is included by the design files.
package ppd_pkg;

   typedef enum logic [3:0] {
      PPD_ST_IDLE    = 4'h1,
      PPD_ST_COLLECT = 4'h2,
      PPD_ST_WAIT    = 4'h4,
      PPD_ST_REPORT  = 4'h8
   } ppd_state_e;

   typedef enum logic [3:0] {
      PPD_ACT_NONE       = 4'h1,
      PPD_ACT_ONE        = 4'h2,
      PPD_ACT_TWO_PRESET = 4'h4,
      PPD_ACT_TWO_SIZED  = 4'h8
   } ppd_action_e;

   typedef struct packed {
      logic        illegal;
      ppd_action_e act;
   } ppd_result_s;

endpackage

// *** pkg/ppd_size_if.sv ***
// Carries the raw partition size and unit to the size converter
// and the converted megabyte count back. One clock domain.
`timescale 1ns/10ps
interface ppd_size_if;
   logic [15:0] size_raw;
   logic [1:0]  unit;
   logic [15:0] size_mb;
   modport conv (input size_raw, input unit, output size_mb);
   modport user (output size_raw, output unit, input size_mb);
endinterface

// *** src/ppd_decoder.sv ***
// Partition page decoder: collects the bytes of one partition page
// and reports the format action or an illegal request.
// Assumes page bytes come from logic on sys_clk, one per valid cycle.
//
// What this block does
// R01: Initiator sends parameters savable flag zero.
// R02: Page code must be 11h.
// R03: Length 06h is short form, 08h long.
// R04: Maximum additional partitions byte is ignored.
// R05: Short form carries zero additional partitions.
// R06: Long form carries 00h or 01h partitions.
// R07: No additional partitions: size bytes disregarded.
// R08: All select bits zero: leave tape unformatted.
// R09: Zero added, fixed or preset: one partition.
// R10: Fixed set: preset and host-sized clear.
// R11: Zero added with host-sized set is unsupported.
// R12: One added with fixed set is unsupported.
// R13: One added, preset only: two, built-in size.
// R14: One added, host-sized, nonzero size: two.
// R15: One added, host-sized with zero size: one partition.
// R16: Preset set alone; several select bits unsupported.
// R17: Host-sized set: fixed and preset clear.
// R18: Units bytes, KB, MB; code 11 illegal; rejected only for host-sized with nonzero size.
// R19: Size to megabytes, round down, minimum one.
// R20: Short eight bytes, long ten, size MSB first.
// R21: Bad combinations rejected as illegal request.
// R22: Outcome given as one of four actions.
`timescale 1ns/10ps
`include "ppd_consts.svh"
module ppd_decoder (
   input  wire logic               sys_clk,
   input  wire logic               resetn,
   input  wire logic               page_byte_valid,
   input  wire logic [7:0]         page_byte,
   input  wire logic               page_last,
   output logic                    page_ready_r,
   output logic                    result_done_r,
   output logic                    illegal_request_r,
   output ppd_pkg::ppd_action_e    format_action_r,
   output logic [15:0]             first_part_mb_r
);
   import ppd_pkg::*;

   ppd_state_e  state_r;
   ppd_state_e  state_nxt;
   logic [3:0]  cnt_r;
   logic [3:0]  cnt_nxt;
   logic [3:0]  idx;
   logic        parameters_savable_flag_r;
   logic        parameters_savable_flag_nxt;
   logic [5:0]  code_r;
   logic [5:0]  code_nxt;
   logic [7:0]  len_r;
   logic [7:0]  len_nxt;
   logic [7:0]  addl_r;
   logic [7:0]  addl_nxt;
   logic [7:0]  sel_r;
   logic [7:0]  sel_nxt;
   logic [15:0] size_r;
   logic [15:0] size_nxt;
   logic        taken;
   logic        done_nxt;
   logic        ready_nxt;
   logic        illegal_nxt;
   ppd_action_e act_nxt;
   logic [15:0] mb_nxt;
   ppd_result_s res;

   ppd_size_if u_sz_if ();

   // Judge the collected page
   function automatic ppd_result_s ppd_judge(
      input logic        savable,
      input logic [5:0]  code,
      input logic [7:0]  len,
      input logic [3:0]  cnt,
      input logic [7:0]  addl,
      input logic [7:0]  sel,
      input logic [15:0] size
   );
      ppd_result_s r;
      logic [2:0]  s3;
      logic        long_f;
      logic        bad;
      r.illegal = 1'b0;
      r.act     = PPD_ACT_NONE;
      s3        = sel[`PPD_FIXED_BIT:`PPD_HOST_BIT];
      long_f    = (len == `PPD_LEN_LONG);
      bad       = savable;                                 // [R01]
      bad       = bad | (code != `PPD_PAGE_CODE);          // [R02]
      bad       = bad | ((len != `PPD_LEN_SHORT) && !long_f); // [R03]
      bad       = bad | (cnt != (long_f ? `PPD_BYTES_LONG
                                        : `PPD_BYTES_SHORT)); // [R20]
      // Byte 2 is never looked at
      bad = bad | (!long_f && addl != `PPD_ADDL_NONE);     // [R05]
      bad = bad | (addl != `PPD_ADDL_NONE &&
                   addl != `PPD_ADDL_ONE);                 // [R06]
      if (bad) begin
         r.illegal = 1'b1;                                 // [R21]
      end else if (addl == `PPD_ADDL_NONE) begin
         // Size bytes do not matter here [R07]
         case (s3)
            3'h0:    r.act = PPD_ACT_NONE;                 // [R08]
            3'h4:    r.act = PPD_ACT_ONE;                  // [R09] [R10]
            3'h2:    r.act = PPD_ACT_ONE;                  // [R09]
            default: r.illegal = 1'b1;                     // [R11] [R16]
         endcase
      end else begin
         case (s3)
            3'h0:    r.act = PPD_ACT_NONE;                 // [R08]
            3'h2:    r.act = PPD_ACT_TWO_PRESET;           // [R13]
            3'h1: begin
               if (size == `PPD_RST_SIZE) begin
                  r.act = PPD_ACT_ONE;                     // [R15]
               end else if (sel[`PPD_UNIT_HI:`PPD_UNIT_LO]
                            == `PPD_UNIT_BAD) begin
                  r.illegal = 1'b1;                        // [R18]
               end else begin
                  r.act = PPD_ACT_TWO_SIZED;               // [R14] [R17]
               end
            end
            default: r.illegal = 1'b1;                     // [R12] [R16]
         endcase
      end
      return r;
   endfunction

   // Size to megabyte converter
   ppd_size_conv u_conv (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .sz      (u_sz_if)
   );

   // Feed the converter from the captured fields
   assign u_sz_if.size_raw = size_r;                       // [R19]
   assign u_sz_if.unit     = sel_r[`PPD_UNIT_HI:`PPD_UNIT_LO];

   // Byte collection and sequencing
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      parameters_savable_flag_nxt = parameters_savable_flag_r;
      code_nxt  = code_r;
      len_nxt   = len_r;
      addl_nxt  = addl_r;
      sel_nxt   = sel_r;
      size_nxt  = size_r;
      idx       = cnt_r;
      taken     = page_byte_valid &&
                  (state_r == PPD_ST_IDLE || state_r == PPD_ST_COLLECT);
      if (state_r == PPD_ST_IDLE) begin
         idx      = `PPD_IDX_CODE;
         cnt_nxt  = `PPD_RST_CNT;
         parameters_savable_flag_nxt = 1'b0;
         code_nxt = 6'h00;
         len_nxt  = `PPD_RST_BYTE;
         addl_nxt = `PPD_RST_BYTE;
         sel_nxt  = `PPD_RST_BYTE;
         size_nxt = `PPD_RST_SIZE;
      end
      if (taken) begin
         if (idx != `PPD_CNT_MAX) begin
            cnt_nxt = 4'(idx + 4'h1);
         end
         case (idx)
            `PPD_IDX_CODE: begin
               parameters_savable_flag_nxt =
                  page_byte[`PPD_SAVABLE_BIT];             // [R01]
               code_nxt = page_byte[5:0];                  // [R02]
            end
            `PPD_IDX_LEN:     len_nxt  = page_byte;        // [R03]
            `PPD_IDX_MAXADD:  addl_nxt = addl_r;           // [R04]
            `PPD_IDX_ADDL:    addl_nxt = page_byte;
            `PPD_IDX_SEL:     sel_nxt  = page_byte;
            `PPD_IDX_SIZE_HI: size_nxt = {page_byte, size_r[7:0]}; // [R20]
            `PPD_IDX_SIZE_LO: size_nxt = {size_r[15:8], page_byte};
            default:          cnt_nxt  = cnt_nxt;
         endcase
      end
      case (state_r)
         PPD_ST_IDLE: begin
            if (taken) begin
               state_nxt = page_last ? PPD_ST_WAIT : PPD_ST_COLLECT;
            end
         end
         PPD_ST_COLLECT: begin
            if (taken && page_last) begin
               state_nxt = PPD_ST_WAIT;
            end
         end
         PPD_ST_WAIT:   state_nxt = PPD_ST_REPORT;
         PPD_ST_REPORT: state_nxt = PPD_ST_IDLE;
         default:       state_nxt = PPD_ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= PPD_ST_IDLE;
         cnt_r   <= `PPD_RST_CNT;
         parameters_savable_flag_r <= 1'b0;
         code_r  <= 6'h00;
         len_r   <= `PPD_RST_BYTE;
         addl_r  <= `PPD_RST_BYTE;
         sel_r   <= `PPD_RST_BYTE;
         size_r  <= `PPD_RST_SIZE;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         parameters_savable_flag_r <= parameters_savable_flag_nxt;
         code_r  <= code_nxt;
         len_r   <= len_nxt;
         addl_r  <= addl_nxt;
         sel_r   <= sel_nxt;
         size_r  <= size_nxt;
      end
   end

   // Result outputs, updated once per page
   always_comb begin
      res         = ppd_judge(parameters_savable_flag_r, code_r, len_r,
                              cnt_r, addl_r, sel_r, size_r);
      ready_nxt   = (state_nxt == PPD_ST_IDLE ||
                     state_nxt == PPD_ST_COLLECT);
      done_nxt    = (state_r == PPD_ST_REPORT);
      illegal_nxt = illegal_request_r;
      act_nxt     = format_action_r;
      mb_nxt      = first_part_mb_r;
      if (state_r == PPD_ST_REPORT) begin
         illegal_nxt = res.illegal;                        // [R21]
         act_nxt     = res.illegal ? PPD_ACT_NONE : res.act; // [R22]
         mb_nxt      = (act_nxt == PPD_ACT_TWO_SIZED) ? u_sz_if.size_mb
                                                      : `PPD_RST_SIZE;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         page_ready_r      <= 1'b1;
         result_done_r     <= 1'b0;
         illegal_request_r <= 1'b0;
         format_action_r   <= PPD_ACT_NONE;
         first_part_mb_r   <= `PPD_RST_SIZE;
      end else begin
         page_ready_r      <= ready_nxt;
         result_done_r     <= done_nxt;
         illegal_request_r <= illegal_nxt;
         format_action_r   <= act_nxt;
         first_part_mb_r   <= mb_nxt;
      end
   end

   // Checks on the decoded result
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   logic [2:0] s3_chk;
   assign s3_chk = sel_r[`PPD_FIXED_BIT:`PPD_HOST_BIT];

   sequence s_last_taken;
      taken && page_last;
   endsequence
   sequence s_report;
      ##3 result_done_r;
   endsequence

   property p_last_to_done;
      s_last_taken |-> s_report;
   endproperty
   a_last_to_done: assert property (p_last_to_done) // [R22]
      else $error("no result three cycles after last byte");

   property p_done_pulse;
      result_done_r |=> !result_done_r [*2];
   endproperty
   a_done_pulse: assert property (p_done_pulse) // [R22]
      else $error("result done is not a single pulse");

   property p_bad_code;
      result_done_r && code_r != `PPD_PAGE_CODE |-> illegal_request_r;
   endproperty
   a_bad_code: assert property (p_bad_code) // [R02]
      else $error("wrong page code accepted");

   property p_bad_len;
      result_done_r && len_r != `PPD_LEN_SHORT &&
      len_r != `PPD_LEN_LONG |-> illegal_request_r;
   endproperty
   a_bad_len: assert property (p_bad_len) // [R03]
      else $error("wrong page length accepted");

   property p_no_format;
      result_done_r && !illegal_request_r && s3_chk == 3'h0
      |-> format_action_r == PPD_ACT_NONE;
   endproperty
   a_no_format: assert property (p_no_format) // [R08]
      else $error("tape formatted with no select bit");

   property p_host_zero_add;
      result_done_r && addl_r == `PPD_ADDL_NONE && s3_chk[0]
      |-> illegal_request_r;
   endproperty
   a_host_zero_add: assert property (p_host_zero_add) // [R11]
      else $error("host sized with no partition accepted");

   property p_fixed_one_add;
      result_done_r && addl_r == `PPD_ADDL_ONE && s3_chk[2]
      |-> illegal_request_r;
   endproperty
   a_fixed_one_add: assert property (p_fixed_one_add) // [R12]
      else $error("fixed with one partition accepted");

   property p_bad_unit;
      result_done_r && !illegal_request_r &&
      format_action_r == PPD_ACT_TWO_SIZED
      |-> sel_r[`PPD_UNIT_HI:`PPD_UNIT_LO] != `PPD_UNIT_BAD &&
          first_part_mb_r != `PPD_RST_SIZE;
   endproperty
   a_bad_unit: assert property (p_bad_unit) // [R18]
      else $error("illegal unit or zero size accepted");

   property p_zero_size;
      result_done_r && !illegal_request_r && s3_chk == 3'h1 &&
      size_r == `PPD_RST_SIZE |-> format_action_r == PPD_ACT_ONE;
   endproperty
   a_zero_size: assert property (p_zero_size) // [R15]
      else $error("zero size did not give one partition");

   property p_preset_two;
      result_done_r && !illegal_request_r && addl_r == `PPD_ADDL_ONE &&
      s3_chk == 3'h2 |-> format_action_r == PPD_ACT_TWO_PRESET;
   endproperty
   a_preset_two: assert property (p_preset_two) // [R13]
      else $error("preset with one partition not two");

   property p_illegal_none;
      illegal_request_r |-> format_action_r == PPD_ACT_NONE;
   endproperty
   a_illegal_none: assert property (p_illegal_none) // [R21]
      else $error("illegal page produced a format action");

endmodule

// *** src/ppd_size_conv.sv ***
// Converts a partition size in bytes, kilobytes or megabytes to
// whole megabytes, registered. Assumes sys_clk and resetn as top.
`timescale 1ns/10ps
`include "ppd_consts.svh"
module ppd_size_conv (
   input  wire logic  sys_clk,
   input  wire logic  resetn,
   ppd_size_if.conv   sz
);
   import ppd_pkg::*;

   logic [15:0] mb_r;
   logic [15:0] mb_nxt;
   logic [15:0] kb_mb;

   // Round down to megabytes, never below one; unit code 11 gives zero
   always_comb begin
      kb_mb = sz.size_raw >> `PPD_KB_SHIFT;
      case (sz.unit)
         `PPD_UNIT_BYTE:  mb_nxt = `PPD_MB_MIN;  // [R19]
         `PPD_UNIT_KBYTE: begin
            mb_nxt = (kb_mb == `PPD_RST_SIZE) ? `PPD_MB_MIN : kb_mb; // [R19]
         end
         `PPD_UNIT_MBYTE: begin
            mb_nxt = (sz.size_raw == `PPD_RST_SIZE) ? `PPD_MB_MIN
                                                     : sz.size_raw;
         end
         default:         mb_nxt = `PPD_RST_SIZE; // [R18]
      endcase
   end

   // Result register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mb_r <= `PPD_RST_SIZE;
      end else begin
         mb_r <= mb_nxt;
      end
   end

   assign sz.size_mb = mb_r;

endmodule

// *** tb/partition_page_decoder_tb.sv ***
// Self-checking bench of the partition page decoder.
// Assumes package, header and interface are compiled before it.
`timescale 1ns/10ps
module partition_page_decoder_tb;
   import ppd_pkg::*;
   localparam logic [7:0]  FX = 8'h80;
   localparam logic [7:0]  PR = 8'h40;
   localparam logic [7:0]  HS = 8'h20;
   localparam logic [7:0]  KB = 8'h08;
   localparam logic [7:0]  MB = 8'h10;
   localparam logic [7:0]  BU = 8'h18;
   localparam ppd_action_e A_NON = PPD_ACT_NONE;
   localparam ppd_action_e A_ONE = PPD_ACT_ONE;
   localparam ppd_action_e A_PRE = PPD_ACT_TWO_PRESET;
   localparam ppd_action_e A_SIZ = PPD_ACT_TWO_SIZED;
   logic                   sys_clk;
   logic                   resetn;
   logic                   page_byte_valid;
   logic [7:0]             page_byte;
   logic                   page_last;
   logic                   page_ready_r;
   logic                   result_done_r;
   logic                   illegal_request_r;
   ppd_action_e            format_action_r;
   logic [15:0]            first_part_mb_r;
   int                     miscompares;
   int                     tests_run;

   ppd_decoder dut (
      .sys_clk           (sys_clk),
      .resetn            (resetn),
      .page_byte_valid   (page_byte_valid),
      .page_byte         (page_byte),
      .page_last         (page_last),
      .page_ready_r      (page_ready_r),
      .result_done_r     (result_done_r),
      .illegal_request_r (illegal_request_r),
      .format_action_r   (format_action_r),
      .first_part_mb_r   (first_part_mb_r)
   );

   ppd_initiator init (
      .sys_clk         (sys_clk),
      .page_byte_valid (page_byte_valid),
      .page_byte       (page_byte),
      .page_last       (page_last)
   );

   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Prints counts and verdict, ends the run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Counts one comparison, reports a mismatch
   task automatic chk(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask

   // Expected megabytes: round down, never below one for bytes and kilobytes
   function automatic logic [15:0] mb_of(input logic [1:0] u,
                                         input logic [15:0] s);
      if (u == 2'b00) return 16'h0001;
      if (u == 2'b01) return ((s >> 10) == 16'h0000) ? 16'h0001 : s >> 10;
      return s;
   endfunction

   // Sends one page and judges the result
   task automatic run(input logic [7:0] b0, ln, addl, sel,
                      input logic [15:0] sz, input int n, input logic ill,
                      input ppd_action_e act, input logic [15:0] mb,
                      input logic junk = 1'b0);
      logic [7:0] pg [16];
      int         k;
      pg = '{b0, ln, 8'hA5, addl, sel, 8'h5A, 8'h00, 8'h00, sz[15:8],
             sz[7:0], 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3C};
      init.send_page(pg, n, junk);
      k = 0;
      while (k < 8 && result_done_r !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         k++;
         if (result_done_r !== 1'b1) begin
            chk(page_ready_r === 1'b0, "ready while decoding");
         end
      end
      chk(result_done_r === 1'b1, "no result pulse");
      chk(page_ready_r === 1'b1, "not ready with result");
      chk(illegal_request_r === ill, "illegal flag wrong");
      chk(format_action_r === act, "action wrong");
      chk(first_part_mb_r === mb, "partition size wrong");
      @(posedge sys_clk);
      #1;
      chk(result_done_r === 1'b0, "result pulse too long");
   endtask

   // Outputs while reset is held and just after release
   task automatic t_reset();
      repeat (3) @(posedge sys_clk);
      #1;
      chk(page_ready_r === 1'b1 && result_done_r === 1'b0, "rst hs");
      chk(illegal_request_r === 1'b0 && first_part_mb_r === 16'h0,
          "rst");
      chk(format_action_r === A_NON, "reset action");
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk(page_ready_r === 1'b1, "not ready after reset");
   endtask

   // Header fields and page byte counts
   task automatic t_basic();
      run(8'h11, 8'h06, 8'h00, FX, 16'h0, 8, 0, A_ONE, 16'h0);
      run(8'h91, 8'h06, 8'h00, FX, 16'h0, 8, 1, A_NON, 16'h0);
      run(8'h12, 8'h06, 8'h00, FX, 16'h0, 8, 1, A_NON, 16'h0);
      run(8'h51, 8'h06, 8'h00, FX, 16'h0, 8, 0, A_ONE, 16'h0);
      run(8'h11, 8'h07, 8'h00, FX, 16'h0, 9, 1, A_NON, 16'h0);
      run(8'h11, 8'h06, 8'h00, FX, 16'h0, 9, 1, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h00, FX, 16'h0, 8, 1, A_NON, 16'h0);
      run(8'h11, 8'h06, 8'h01, PR, 16'h0, 8, 1, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h02, PR, 16'h5, 10, 1, A_NON, 16'h0);
   endtask

   // No additional partitions on the long form
   task automatic t_no_addl();
      run(8'h11, 8'h08, 8'h00, 8'h07, 16'h9, 10, 0, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h00, FX, 16'h1234, 10, 0, A_ONE, 16'h0);
      run(8'h11, 8'h08, 8'h00, PR, 16'h1234, 10, 0, A_ONE, 16'h0);
      run(8'h11, 8'h08, 8'h00, HS, 16'h0005, 10, 1, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h00, 8'hC0, 16'h0, 10, 1, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h00, 8'hA0, 16'h0, 10, 1, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h00, 8'hE0, 16'h0, 10, 1, A_NON, 16'h0);
   endtask

   // One additional partition
   task automatic t_one_addl();
      run(8'h11, 8'h08, 8'h01, 8'h00, 16'h5, 10, 0, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h01, FX, 16'h5, 10, 1, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h01, PR | BU, 16'h7, 10, 0, A_PRE, 16'h0);
      run(8'h11, 8'h08, 8'h01, HS | MB, 16'h5, 10, 0, A_SIZ, 16'h5);
      run(8'h11, 8'h08, 8'h01, HS | MB, 16'h0, 10, 0, A_ONE, 16'h0);
      run(8'h11, 8'h08, 8'h01, 8'h60, 16'h5, 10, 1, A_NON, 16'h0);
      run(8'h11, 8'h08, 8'h01, 8'hA0, 16'h5, 10, 1, A_NON, 16'h0);
   endtask

   // Size units and megabyte conversion
   task automatic t_units();
      run(8'h11, 8'h08, 8'h01, HS | KB, 16'h0C00, 10, 0, A_SIZ,
          mb_of(2'b01, 16'h0C00));
      run(8'h11, 8'h08, 8'h01, HS | KB, 16'h03FF, 10, 0, A_SIZ,
          mb_of(2'b01, 16'h03FF));
      run(8'h11, 8'h08, 8'h01, HS, 16'h8000, 10, 0, A_SIZ,
          mb_of(2'b00, 16'h8000));
      run(8'h11, 8'h08, 8'h01, HS | MB, 16'hFFFF, 10, 0, A_SIZ,
          mb_of(2'b10, 16'hFFFF));
      run(8'h11, 8'h08, 8'h01, HS | BU, 16'h5, 10, 1, A_NON, 16'h0);
   endtask

   // Stray byte while busy is ignored; next page decodes cleanly
   task automatic t_refused();
      run(8'h11, 8'h06, 8'h00, PR, 16'h0, 8, 0, A_ONE, 16'h0, 1);
      run(8'h11, 8'h06, 8'h00, FX, 16'h0, 8, 0, A_ONE, 16'h0);
      run(8'h11, 8'h06, 8'h00, FX, 16'h0, 8, 0, A_ONE, 16'h0);
   endtask

   // Hang guard, well beyond the few hundred cycles needed
   initial begin
      repeat (5000) @(posedge sys_clk);
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end

   // Main sequence
   initial begin
      miscompares = 0;
      tests_run   = 0;
      resetn      = 1'b0;
      t_reset();
      t_basic();
      t_no_addl();
      t_one_addl();
      t_units();
      t_refused();
      tally_and_finish();
   end
endmodule

// *** tb/ppd_initiator.sv ***
// Behavioural initiator model: offers partition page bytes, one a cycle.
// Assumes sys_clk from the bench and a decoder that is ready when idle.
`timescale 1ns/10ps
module ppd_initiator (
   input  wire logic       sys_clk,
   output logic            page_byte_valid,
   output logic [7:0]      page_byte,
   output logic            page_last
);
   // Idle bus at time zero
   initial begin
      page_byte_valid = 1'b0;
      page_byte       = 8'h00;
      page_last       = 1'b0;
   end

   // Sends n bytes back to back, then an optional stray byte
   task automatic send_page(input logic [7:0] pg [16], input int n,
                            input logic junk);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge sys_clk);
         page_byte_valid <= 1'b1;
         page_byte       <= pg[i]; // Size MSB before LSB
         page_last       <= (i == n - 1);
      end
      @(posedge sys_clk);
      if (junk) begin
         page_byte_valid <= 1'b1;
         page_byte       <= 8'h11;
         page_last       <= 1'b0;
         @(posedge sys_clk);
      end
      // Released data shows the inverse, never the stale byte
      page_byte_valid <= 1'b0;
      page_byte       <= ~page_byte;
      page_last       <= 1'b0;
   endtask
endmodule
